// ---- bss_pkg.sv ----
// Purpose: Constants for the buck start-up sequencer
// Assumes: 25 MHz system clock
// Notes:   Ramp reference is a digital code in microvolt steps
package bss_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  // Soft-start ramp, microvolts
  localparam int unsigned RAMP_UV_PER_US  = 200;
  localparam int unsigned RAMP_START_UV   = 0;
  localparam int unsigned RAMP_END_UV     = 1_500_000;
  localparam int unsigned START_LO_UV     = 150_000;
  localparam int unsigned START_HI_UV     = 750_000;
  localparam int unsigned RAMP_W          = 21;
  localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
  // Switching frequency limits, kilohertz; period limits derived in clock cycles
  localparam int unsigned FSW_MIN_KHZ     = 300;
  localparam int unsigned FSW_MAX_KHZ     = 1500;
  localparam int unsigned PER_MAX_CYC     = CLK_HZ / (FSW_MIN_KHZ * 1000);
  localparam int unsigned PER_MIN_CYC     = CLK_HZ / (FSW_MAX_KHZ * 1000);
  localparam int unsigned PER_W           = 7;
  // Pre-bias stepping
  localparam int unsigned STEP_EIGHTHS    = 8;
  localparam int unsigned PULSES_PER_STEP = 16;
  localparam int unsigned STEP_LEVELS     = 8;
  // Enable-to-ramp delay, microseconds
  localparam int unsigned EN_DELAY_US     = 100;
  localparam int unsigned EN_DELAY_CYC    = EN_DELAY_US * CYC_PER_US;
  localparam int unsigned ERR_W           = 8;

  typedef enum logic [1:0] {
    BSS_OFF   = 2'b00,
    BSS_DELAY = 2'b01,
    BSS_RAMP  = 2'b10,
    BSS_RUN   = 2'b11
  } bss_state_e;
endpackage

// ---- bss_osc.sv ----
// Purpose: Switching-period generator and PWM ramp
// Assumes: Period count programmed from the frequency resistor decode
// Notes:   Period clamped to the supported frequency window
`timescale 1ns/100ps
module bss_osc #(
  parameter int unsigned PER_W = 7
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  // Control
  input  wire logic [PER_W-1:0] period_i,
  input  wire logic [PER_W-1:0] per_min_i,
  input  wire logic [PER_W-1:0] per_max_i,
  // Timing outputs
  output logic      [PER_W-1:0] phase_o,
  output logic      [PER_W-1:0] period_o,
  output logic                  tick_o
);
  logic [PER_W-1:0] cnt;
  logic [PER_W-1:0] next_cnt;
  wire  [PER_W-1:0] clamped = (period_i < per_min_i) ? per_min_i :
                              (period_i > per_max_i) ? per_max_i : period_i;
  wire              wrap    = (cnt >= period_o - PER_W'(1));

  assign next_cnt = wrap ? '0 : cnt + PER_W'(1);
  assign phase_o  = cnt;
  assign tick_o   = wrap;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt      <= '0;
      period_o <= PER_W'(83);
    end else begin
      cnt <= next_cnt;
      if (wrap) begin
        period_o <= clamped;
      end
    end
  end
endmodule

// ---- bss_top.sv ----
// Purpose: Start-up sequencer for a voltage-mode synchronous step-down regulator
// Assumes: Comparator inputs are asynchronous; one 25 MHz clock
// Notes:   Ramp reference is a digital code; error amp is a digital code
`timescale 1ns/100ps
module bss_top
  import bss_pkg::*;
#(
  parameter int unsigned EN_DELAY = bss_pkg::EN_DELAY_CYC,
  parameter int unsigned US_CYC   = bss_pkg::CYC_PER_US
) (
  // Clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_n_i,
  // Lockout comparators
  input  wire logic                       bias_ok_i,
  input  wire logic                       enable_ok_i,
  // Loop inputs
  input  wire logic [bss_pkg::ERR_W-1:0]  error_amp_i,
  input  wire logic [bss_pkg::PER_W-1:0]  period_cfg_i,
  // Gate drivers
  output logic                            high_side_on_o,
  output logic                            low_side_on_o,
  // Status
  output logic                            supply_valid_o,
  output logic                            guards_enable_o,
  output logic                            start_window_o,
  output logic [bss_pkg::RAMP_W-1:0]      ramp_ref_o,
  output logic [bss_pkg::ERR_W-1:0]       pwm_ramp_o
);
  import bss_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] bias_sync;
  logic [1:0] en_sync;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bias_sync <= 2'b00;
      en_sync   <= 2'b00;
    end else begin
      bias_sync <= {bias_sync[0], bias_ok_i};
      en_sync   <= {en_sync[0], enable_ok_i};
    end
  end

  // Enable comparator hysteresis (1.2 V rise, 1.0 V fall) lives in the analog front end
  wire bias_ok = bias_sync[1];
  wire en_ok   = en_sync[1];
  wire valid   = bias_ok & en_ok;

  // ----------------------------------------
  // Switching oscillator
  // ----------------------------------------
  logic [PER_W-1:0] phase;
  logic [PER_W-1:0] period;
  logic             tick;

  bss_osc #(
    .PER_W (PER_W)
  ) u_osc (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .period_i  (period_cfg_i),
    .per_min_i (PER_W'(PER_MIN_CYC)),
    .per_max_i (PER_W'(PER_MAX_CYC)),
    .phase_o   (phase),
    .period_o  (period),
    .tick_o    (tick)
  );

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  bss_state_e state;
  bss_state_e next_state;
  logic [23:0] dly_cnt;
  logic [7:0]  us_cnt;
  logic [RAMP_W-1:0] ramp;
  wire         ramp_done = (ramp >= RAMP_W'(RAMP_END_UV));
  wire         us_tick   = (us_cnt == 8'(US_CYC - 1));
  wire         dly_done  = (dly_cnt >= 24'(EN_DELAY - 1));

  always_comb begin
    next_state = state;
    case (state)
      BSS_OFF:   next_state = valid ? BSS_DELAY : BSS_OFF;
      BSS_DELAY: next_state = dly_done ? BSS_RAMP : BSS_DELAY;
      BSS_RAMP:  next_state = ramp_done ? BSS_RUN : BSS_RAMP;
      BSS_RUN:   next_state = BSS_RUN;
      default:   next_state = BSS_OFF;
    endcase
    if (!valid) begin
      next_state = BSS_OFF;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= BSS_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly_cnt <= '0;
    end else if (state == BSS_DELAY && valid) begin
      dly_cnt <= dly_cnt + 24'd1;
    end else begin
      dly_cnt <= '0;
    end
  end

  // ----------------------------------------
  // Soft-start reference ramp
  // ----------------------------------------
  // One microvolt-per-code; 0.2 mV/us means 200 codes per microsecond
  wire ramp_run = (state == BSS_RAMP) && valid;
  wire [RAMP_W-1:0] ramp_sum = ramp + RAMP_W'(RAMP_UV_PER_US);
  wire [RAMP_W-1:0] next_ramp = (ramp_sum > RAMP_W'(RAMP_END_UV)) ?
                                RAMP_W'(RAMP_END_UV) : ramp_sum;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      us_cnt <= '0;
    end else if (!ramp_run || us_tick) begin
      us_cnt <= '0;
    end else begin
      us_cnt <= us_cnt + 8'd1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ramp <= RAMP_W'(RAMP_START_UV);
    end else if (!valid || state == BSS_OFF) begin
      ramp <= RAMP_W'(RAMP_START_UV);
    end else if (ramp_run && us_tick) begin
      ramp <= next_ramp;
    end
  end

  assign ramp_ref_o     = ramp;
  // Fixed 3 ms window since the ramp slope is fixed
  assign start_window_o = (ramp >= RAMP_W'(START_LO_UV)) &&
                          (ramp < RAMP_W'(START_HI_UV));

  // ----------------------------------------
  // PWM comparator
  // ----------------------------------------
  function automatic logic [ERR_W-1:0] scale_phase(input logic [PER_W-1:0] ph,
                                                   input logic [PER_W-1:0] per);
    logic [PER_W+ERR_W-1:0] prod;
    prod = {ph, {ERR_W{1'b0}}} / {{ERR_W{1'b0}}, per};
    scale_phase = prod[ERR_W-1:0];
  endfunction

  wire [ERR_W-1:0] pwm_ramp = scale_phase(phase, period);
  wire switching = (state == BSS_RAMP || state == BSS_RUN) && valid;
  wire hs_raw    = switching && (error_amp_i > pwm_ramp);

  // ----------------------------------------
  // Pre-bias low-side stepping
  // ----------------------------------------
  logic       first_hs;
  logic [3:0] pulse_cnt;
  logic [3:0] level;
  logic       prebias_done;
  wire [PER_W+3:0] ls_start_w = {period, 3'b000} -
                                (PER_W+4)'(period) * (PER_W+4)'({1'b0, level} + 5'd1);
  // Low-side window is the tail of the period, width (level+1)/8
  wire [PER_W-1:0] ls_start = ls_start_w[PER_W+2:3];
  wire ls_step = !hs_raw && (phase >= ls_start);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_hs <= 1'b0;
    end else if (!switching) begin
      first_hs <= 1'b0;
    end else if (hs_raw) begin
      first_hs <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_cnt    <= '0;
      level        <= '0;
      prebias_done <= 1'b0;
    end else if (!valid || !switching) begin
      pulse_cnt    <= '0;
      level        <= '0;
      prebias_done <= 1'b0;
    end else if (tick && first_hs && !prebias_done) begin
      pulse_cnt <= pulse_cnt + 4'd1;
      if (pulse_cnt == 4'(PULSES_PER_STEP - 1)) begin
        if (level == 4'(STEP_LEVELS - 1)) begin
          prebias_done <= 1'b1;
        end else begin
          level <= level + 4'd1;
        end
      end
    end
  end

  // ----------------------------------------
  // Gate drive outputs
  // ----------------------------------------
  wire ls_raw = switching && first_hs &&
                (prebias_done ? !hs_raw : ls_step);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      high_side_on_o <= 1'b0;
      low_side_on_o  <= 1'b0;
      pwm_ramp_o     <= '0;
    end else begin
      high_side_on_o <= hs_raw & valid;
      low_side_on_o  <= ls_raw & valid & ~hs_raw;
      pwm_ramp_o     <= pwm_ramp;
    end
  end

  assign supply_valid_o  = valid;
  assign guards_enable_o = switching;

endmodule

// ---- bss_cmp_model.sv ----
// Purpose: Lockout comparators in front of the sequencer
// Assumes: Levels in millivolts
// Notes:   Bias thresholds are plain defaults
`timescale 1ns/100ps
module bss_cmp_model #(
  parameter int unsigned BIAS_ON  = 4100,
  parameter int unsigned BIAS_OFF = 3800,
  parameter int unsigned EN_ON    = 1200,
  parameter int unsigned EN_OFF   = 1000
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Levels
  input  wire logic [15:0] bias_mv_i,
  input  wire logic [15:0] en_mv_i,
  // Comparators
  output logic             bias_ok_o,
  output logic             enable_ok_o
);
  // Hysteresis stops a slow edge chattering
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bias_ok_o   <= 1'b0;
      enable_ok_o <= 1'b0;
    end else begin
      if (bias_mv_i > BIAS_ON) bias_ok_o <= 1'b1;
      else if (bias_mv_i < BIAS_OFF) bias_ok_o <= 1'b0;
      if (en_mv_i > EN_ON) enable_ok_o <= 1'b1;
      else if (en_mv_i < EN_OFF) enable_ok_o <= 1'b0;
    end
  end
endmodule

// ---- bss_top_assertions.sv ----
// Purpose: Port checks of the start-up sequencer
// Assumes: Default 25 cycles per ramp step
// Notes:   Bound to bss_top
`timescale 1ns/100ps
module bss_top_assertions
  import bss_pkg::*;
#(
  parameter int unsigned EN_DELAY = 20
) (
  // Clock and reset
  input wire logic                      sys_clk_i,
  input wire logic                      rst_n_i,
  // Comparators
  input wire logic                      bias_ok_i,
  input wire logic                      enable_ok_i,
  // Outputs
  input wire logic                      high_side_on_o,
  input wire logic                      low_side_on_o,
  input wire logic                      supply_valid_o,
  input wire logic                      guards_enable_o,
  input wire logic                      start_window_o,
  input wire logic [bss_pkg::RAMP_W-1:0] ramp_ref_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [31:0] vcnt;
  logic        seen_high;
  // Cleared only once gates are quiet after lockout
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vcnt      <= '0;
      seen_high <= 1'b0;
    end else begin
      vcnt      <= !supply_valid_o ? '0 : (vcnt < 32'h00ffffff ? vcnt + 32'h1 : vcnt);
      seen_high <= high_side_on_o | (seen_high & (supply_valid_o | low_side_on_o));
    end
  end
  AST_LOCKOUT_OFF: assert property ((!bias_ok_i || !enable_ok_i) [*4] |->
    !high_side_on_o && !low_side_on_o && !supply_valid_o) else $error("gates on in lockout");
  AST_VALID_CAUSE: assert property (supply_valid_o |->
    $past(bias_ok_i, 2) && $past(enable_ok_i, 2)) else $error("valid without inputs");
  AST_VALID_RISE: assert property ((bias_ok_i && enable_ok_i) [*3] |->
    supply_valid_o) else $error("valid late");
  AST_EN_DELAY: assert property (supply_valid_o && vcnt < EN_DELAY |->
    ramp_ref_o == '0) else $error("ramp before delay");
  AST_RAMP_STEP: assert property (ramp_ref_o > $past(ramp_ref_o) |->
    ramp_ref_o == $past(ramp_ref_o) + 21'd200) else $error("ramp step size");
  AST_RAMP_RATE: assert property (ramp_ref_o > $past(ramp_ref_o) && ramp_ref_o >= 21'd600 |->
    $past(ramp_ref_o, 25) == ramp_ref_o - 21'd200 && $past(ramp_ref_o, 26) == ramp_ref_o - 21'd400)
    else $error("ramp step spacing");
  AST_START_WIN: assert property (start_window_o && supply_valid_o |->
    ramp_ref_o >= 21'd149800 && ramp_ref_o <= 21'd750200) else $error("window outside ramp");
  AST_PREBIAS_LOW: assert property (!seen_high |-> !low_side_on_o)
    else $error("low side before high side");
  AST_NO_OVERLAP: assert property (!(high_side_on_o && low_side_on_o))
    else $error("both gates on");
  AST_GUARDS: assert property (supply_valid_o && ramp_ref_o != '0 |-> guards_enable_o)
    else $error("guards off in ramp");
endmodule
bind bss_top bss_top_assertions #(.EN_DELAY(EN_DELAY)) i_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .bias_ok_i(bias_ok_i), .enable_ok_i(enable_ok_i), .high_side_on_o(high_side_on_o),
  .low_side_on_o(low_side_on_o), .supply_valid_o(supply_valid_o), .guards_enable_o(guards_enable_o),
  .start_window_o(start_window_o), .ramp_ref_o(ramp_ref_o));

// ---- bss_top_bench.sv ----
// Purpose: Self-checking bench of the start-up sequencer
// Assumes: Period of 80 clocks, short enable delay
// Notes:   Glitches hold lockout long enough to clear state
`timescale 1ns/100ps
module bss_top_bench;
  import bss_pkg::*;
  localparam int unsigned PER = 80;
  logic              sys_clk_i, rst_n_i, bok, eok, hs, ls, vld, grd, win;
  logic [ERR_W-1:0]  ea, pwm;
  logic [PER_W-1:0]  per;
  logic [RAMP_W-1:0] ramp;
  logic [15:0]       bmv, emv;
  logic [31:0]       seed, ws[$];
  int                errors, samples_checked, n, w;
  bss_top #(.EN_DELAY(20)) i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bias_ok_i(bok),
    .enable_ok_i(eok), .error_amp_i(ea), .period_cfg_i(per), .high_side_on_o(hs), .low_side_on_o(ls),
    .supply_valid_o(vld), .guards_enable_o(grd), .start_window_o(win), .ramp_ref_o(ramp), .pwm_ramp_o(pwm));
  bss_cmp_model i_cmp (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bias_mv_i(bmv), .en_mv_i(emv),
    .bias_ok_o(bok), .enable_ok_o(eok));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // High side is on 5 clocks when error code is 8'h10
  function automatic logic [31:0] exp_w(input int i);
    return (i / 16 >= 7) ? PER - 5 : (i / 16 + 1) * PER / 8;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk_i);
  endtask
  task automatic drive(input logic [15:0] b, input logic [15:0] e, input logic [7:0] a);
    @(posedge sys_clk_i);
    bmv <= b;
    emv <= e;
    ea  <= a;
  endtask
  task automatic conclude();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #4_000_000;
    errors++;
    conclude();
  end
  initial begin
    rst_n_i = 1'b0;
    {bmv, emv, ea, errors, samples_checked} = '0;
    per  = PER[PER_W-1:0];
    seed = 32'h5ba2fc58;
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    drive(16'd5000, 16'd1100, 8'h10);
    tick(10);
    chk("valid_en_low", 0, {31'h0, vld});
    chk("high_locked", 0, {31'h0, hs});
    drive(16'd5000, 16'd1250, 8'h10);
    for (n = 0; eok !== 1'b1 && n < 10; n++) tick(1);
    for (n = 0; vld !== 1'b1 && n < 10; n++) tick(1);
    chk("valid_latency", 2, n);
    // Low pulse widths through all levels and after
    for (n = 0, w = 0; ws.size() < 136 && n < 20000; n++) begin
      tick(1);
      if (ls === 1'b1) w++;
      else if (w != 0) begin
        ws.push_back(w);
        w = 0;
      end
    end
    foreach (ws[i]) chk("low_width", exp_w(i), ws[i]);
    for (n = 0; win !== 1'b1 && n < 30000; n++) tick(1);
    chk("ramp_at_window", 150000, {11'h0, ramp});
    drive(16'd5000, 16'd1100, 8'h10);
    tick(8);
    chk("valid_hyst", 1, {31'h0, vld});
    drive(16'd5000, 16'd900, 8'h10);
    tick(5);
    chk("valid_off", 0, {31'h0, vld});
    chk("gates_off", 0, {30'h0, hs, ls});
    chk("ramp_cleared", 0, {11'h0, ramp});
    for (int k = 0; k < 20; k++) begin
      seed = xs(seed);
      drive(16'd4200 + seed[24:16], 16'd1250, seed[7:0]);
      tick(4);
      chk("recover", 1, {31'h0, vld});
      tick(100 + seed[10:0]);
      drive(16'd3000 + seed[18:12], 16'd1250, seed[7:0]);
      tick(5 + seed[21:19]);
      chk("glitch_off", 0, {29'h0, hs, ls, vld});
      chk("glitch_ramp", 0, {11'h0, ramp});
    end
    // Period below the supported window must clamp to the shortest period
    drive(16'd5000, 16'd1250, 8'h10);
    per <= 7'd10;
    tick(300);
    chk("guards_on", 1, {31'h0, grd});
    for (n = 0, w = 0; n < 160; n++) begin
      tick(1);
      if (hs === 1'b1) w++;
      chk("pwm_cmp", {31'h0, pwm < 8'h10}, {31'h0, hs});
    end
    chk("period_clamp", 10, w);
    conclude();
  end
endmodule
